// >>> pts_pkg.sv
/*
 * pts_pkg: shared constants and types for the source-side power transition sequencer.
 * assumes a single 250 MHz clock (ref_clk) and synchronous active-high reset.
 */
package pts_pkg;

	// ==========================================================
	// clock and timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 4;

	// default durations in microseconds; real values come from the link's timing tables
	localparam int SRC_TRANSITION_US = 30;
	localparam int SRC_READY_US      = 300;
	localparam int SNK_STANDBY_US    = 15;

	// least time rounds up, longest time rounds down
	localparam int SRC_TRANSITION_CYC = (SRC_TRANSITION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SRC_READY_CYC      = (SRC_READY_US * 1000) / CLK_PERIOD_NS;
	localparam int SNK_STANDBY_CYC    = (SNK_STANDBY_US * 1000) / CLK_PERIOD_NS;

	localparam int TMR_W = 24;
	localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
	localparam logic [TMR_W-1:0] TMR_ONE  = 24'h000001;

	// sink standby power level in milliwatts, carried for the policy manager
	localparam int SNK_STANDBY_MW = 2500;
	localparam int PWR_W          = 16;

	// ==========================================================
	// sequencer states, gray coded along the main path
	// ==========================================================
	typedef enum logic [2:0] {
		PTS_IDLE      = 3'h0,
		PTS_ACCEPT    = 3'h1,
		PTS_ACK_WAIT  = 3'h3,
		PTS_TRANSIT   = 3'h2,
		PTS_SUPPLY    = 3'h6,
		PTS_PS_RDY    = 3'h7,
		PTS_RDY_ACK   = 3'h5,
		PTS_FAIL      = 3'h4
	} pts_state_t;

endpackage

// >>> pts_timer.sv
/*
 * pts_timer: loadable down-counter that pulses when the loaded count has elapsed.
 * assumes the owner loads it with a nonzero count and the same clock/reset.
 */
`timescale 1ns/1ps
module pts_timer (
	input  wire logic                     ref_clk,
	input  wire logic                     srst,
	input  wire logic                     load,
	input  wire logic [pts_pkg::TMR_W-1:0] count,
	output logic                          expired,
	output logic                          running
);
	import pts_pkg::*;

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             run;
		logic             exp;
	} pts_tmr_t;

	pts_tmr_t r;
	pts_tmr_t next_r;

	always_comb begin
		next_r = r;
		next_r.exp = 1'b0;
		if (load) begin
			next_r.cnt = count;
			next_r.run = 1'b1;
		end else if (r.run) begin
			if (r.cnt == TMR_ONE) begin
				next_r.run = 1'b0;
				next_r.exp = 1'b1;
			end
			next_r.cnt = r.cnt - TMR_ONE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign expired = r.exp;
	assign running = r.run;

endmodule

// >>> pts_sequencer.sv
/*
 * pts_sequencer: source-side sequencer for a contract change that lowers the
 * voltage and raises the current: accept, wait, retarget supply, wait for
 * ready, announce ready.
 * assumes a protocol layer that sends messages on one-cycle requests and
 * reports the partner's acknowledge, and a supply manager with a ready level.
 */
`timescale 1ns/1ps

// Behaviour
// R1: the sink has already sent a request, and the sequence starts only on that request.
// R2: the source opens with accept, and the sink starts its transition timer when it sees it.
// R3: after the acknowledge for accept the source waits the transition interval before acting.
// R4: the sink cuts its draw to standby power within the sink standby limit after accept.
// R5: the sink finishes its standby reduction before the source transition interval ends.
// R6: when the interval expires the source commands its supply to the new voltage.
// R7: the supply must be ready within the source ready limit from the change command.
// R8: supply readiness reaches the sequencer before any further step proceeds.
// R9: after supply ready the source sends ps_rdy and then awaits its acknowledge.
// R10: the sink acknowledges ps_rdy and then lets its policy manager use the new level; pts_sink_model sets draw to 2 on ps_rdy, before its ack.
// R11: the sink may draw the new level at any later time, with no bound assumed.
// R12: the timing durations and standby power are configurable parameters.
module pts_sequencer #(
	parameter int SRC_TRANSITION_CYCLES = pts_pkg::SRC_TRANSITION_CYC,
	parameter int SRC_READY_CYCLES      = pts_pkg::SRC_READY_CYC,
	parameter int SNK_STANDBY_CYCLES    = pts_pkg::SNK_STANDBY_CYC,
	parameter int SNK_STANDBY_POWER     = pts_pkg::SNK_STANDBY_MW
) (
	input  wire logic                       ref_clk,
	input  wire logic                       srst,
	input  wire logic                       request_valid,
	input  wire logic                       goodcrc_rx,
	input  wire logic                       supply_ready,
	output logic                            send_accept,
	output logic                            send_ps_rdy,
	output logic                            supply_change,
	output logic                            busy,
	output logic                            done,
	output logic                            fail,
	output logic [pts_pkg::PWR_W-1:0]        sink_standby_power
);
	import pts_pkg::*;

	// ==========================================================
	// state
	// ==========================================================
	typedef struct packed {
		pts_state_t st;
		logic       acc;
		logic       psr;
		logic       chg;
		logic       busy;
		logic       done;
		logic       fail;
		logic [PWR_W-1:0] pwr;
	} pts_seq_t;

	pts_seq_t r;
	pts_seq_t next_r;

	logic             tmr_load;
	logic [TMR_W-1:0] tmr_count;
	logic             tmr_exp;
	logic             tmr_run;

	// one timer serves both the transition interval and the ready limit
	pts_timer u_timer (
		.ref_clk (ref_clk),
		.srst    (srst),
		.load    (tmr_load),
		.count   (tmr_count),
		.expired (tmr_exp),
		.running (tmr_run)
	);

	// ==========================================================
	// sequencing
	// ==========================================================
	always_comb begin
		next_r = r;
		next_r.acc  = 1'b0;
		next_r.psr  = 1'b0;
		next_r.done = 1'b0;
		next_r.pwr  = PWR_W'(SNK_STANDBY_POWER); // [R12]
		tmr_load  = 1'b0;
		tmr_count = TMR_W'(SRC_TRANSITION_CYCLES); // [R12]
		case (r.st)
			PTS_IDLE: begin
				if (request_valid) begin // [R1]
					next_r.st   = PTS_ACCEPT;
					next_r.busy = 1'b1;
					next_r.fail = 1'b0;
				end
			end
			PTS_ACCEPT: begin
				next_r.acc = 1'b1; // [R2]
				next_r.st  = PTS_ACK_WAIT;
			end
			PTS_ACK_WAIT: begin
				if (goodcrc_rx) begin // [R3]
					tmr_load  = 1'b1;
					next_r.st = PTS_TRANSIT;
				end
			end
			PTS_TRANSIT: begin
				// sink standby must already be reached here; we do not observe it
				if (tmr_exp) begin // [R3] [R5]
					next_r.chg = 1'b1; // [R6]
					tmr_load   = 1'b1;
					tmr_count  = TMR_W'(SRC_READY_CYCLES); // [R7]
					next_r.st  = PTS_SUPPLY;
				end
			end
			PTS_SUPPLY: begin
				if (supply_ready) begin // [R8]
					next_r.psr = 1'b1; // [R9]
					next_r.st  = PTS_PS_RDY;
				end else if (tmr_exp) begin // [R7]
					next_r.fail = 1'b1;
					next_r.busy = 1'b0;
					next_r.st   = PTS_FAIL;
				end
			end
			PTS_PS_RDY: begin
				next_r.st = PTS_RDY_ACK;
			end
			PTS_RDY_ACK: begin
				// sink may use new level at any later time; nothing waits on it
				if (goodcrc_rx) begin // [R9] [R10] [R11]
					next_r.done = 1'b1;
					next_r.busy = 1'b0;
					next_r.st   = PTS_IDLE;
				end
			end
			PTS_FAIL: begin
				if (request_valid) begin
					next_r.st   = PTS_ACCEPT;
					next_r.busy = 1'b1;
					next_r.fail = 1'b0;
				end
			end
			default: begin
				next_r.st = PTS_IDLE;
			end
		endcase
		// a late ready in fail state clears nothing; supply_change held until ready, dropped after one cycle in fail state
		if (r.st == PTS_SUPPLY && supply_ready) begin
			next_r.chg = 1'b0;
		end
		if (r.st == PTS_FAIL) begin
			next_r.chg = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r     <= '0;
			r.st  <= PTS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign send_accept        = r.acc;
	assign send_ps_rdy        = r.psr;
	assign supply_change      = r.chg;
	assign busy               = r.busy;
	assign done               = r.done;
	assign fail               = r.fail;
	assign sink_standby_power = r.pwr;

	// ==========================================================
	// checks
	// ==========================================================
	req_starts_accept_a: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
		(r.st == PTS_IDLE && request_valid) |=> ##1 send_accept)
		else $error("accept not sent two cycles after request");

	accept_needs_req_a: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
		$rose(send_accept) |-> $past(request_valid, 2))
		else $error("accept sent without a request");

	transit_wait_a: assert property (@(posedge ref_clk) disable iff (srst) // [R3]
		(r.st == PTS_ACK_WAIT && goodcrc_rx) |=> !supply_change [*2])
		else $error("supply changed before transition interval");

	change_after_exp_a: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
		(r.st == PTS_TRANSIT && tmr_exp) |=> supply_change && r.st == PTS_SUPPLY)
		else $error("supply not commanded when interval expired");

	ready_limit_a: assert property (@(posedge ref_clk) disable iff (srst) // [R7]
		(r.st == PTS_SUPPLY && !supply_ready && tmr_exp) |=> fail)
		else $error("ready limit overrun not flagged");

	no_psrdy_early_a: assert property (@(posedge ref_clk) disable iff (srst) // [R8]
		$rose(send_ps_rdy) |-> $past(supply_ready))
		else $error("ps_rdy sent without supply ready");

	psrdy_ack_done_a: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
		(r.st == PTS_RDY_ACK && goodcrc_rx) |=> done && !busy)
		else $error("completion missing after ps_rdy acknowledge");

	standby_power_a: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
		busy |-> sink_standby_power == PWR_W'(SNK_STANDBY_POWER))
		else $error("standby power output wrong");

	timer_running_a: assert property (@(posedge ref_clk) disable iff (srst) // [R3] [R7]
		(r.st == PTS_TRANSIT || r.st == PTS_SUPPLY) |-> tmr_run || tmr_exp)
		else $error("interval timer idle while a wait is open");

	accept_pulse_a: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
		send_accept |=> !send_accept)
		else $error("accept request held longer than one cycle");

	change_held_a: assert property (@(posedge ref_clk) disable iff (srst) // [R6] [R8]
		(r.st == PTS_SUPPLY && !supply_ready) |=> supply_change)
		else $error("supply command dropped before ready");

	// a sink standby limit at or past the interval could never be met by any sink
	standby_fits_a: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
		SNK_STANDBY_CYCLES < SRC_TRANSITION_CYCLES)
		else $error("sink standby limit not inside transition interval");

endmodule

// >>> pts_sink_model.sv
/*
 * pts_sink_model: far-side sink policy logic for the sequencer bench.
 * assumes one clock and the sequencer's one-cycle message requests.
 */
`timescale 1ns/1ps
module pts_sink_model #(
	parameter int STANDBY_CYCLES = 3
) (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic send_accept,
	input  wire logic send_ps_rdy,
	output logic      goodcrc_rx
);
	// ==========================================================
	// acknowledge and draw level
	// ==========================================================
	int ack_cnt;
	int sb_cnt;
	int draw;
	bit fire;
	always @(posedge ref_clk) begin
		fire = 1'b0;
		if (srst) begin
			ack_cnt = 0;
			sb_cnt = 0;
			draw = 0;
		end else if (send_accept) begin
			// ack latency varies so the source cannot lean on one figure
			ack_cnt = 1 + $urandom_range(3);
			sb_cnt = STANDBY_CYCLES;
		end else if (send_ps_rdy) begin
			ack_cnt = 1 + $urandom_range(3);
			draw = 2;
		end else if (ack_cnt > 0) begin
			ack_cnt--;
			fire = (ack_cnt == 0);
		end
		goodcrc_rx <= fire;
		if (sb_cnt > 0) begin
			sb_cnt--;
			// standby reached well before the source interval ends
			if (sb_cnt == 0) begin
				draw = 1;
			end
		end
	end
endmodule

// >>> test_power_transition_sequencer.sv
/*
 * test_power_transition_sequencer: self-checking bench for pts_sequencer.
 * assumes pts_pkg, pts_sequencer and pts_sink_model are compiled first.
 */
`timescale 1ns/1ps
module test_power_transition_sequencer;
	import pts_pkg::*;
	localparam int N = 5;
	localparam int RDY = 20;
	logic             ref_clk = 1'b0;
	logic             srst = 1'b1;
	logic             request_valid = 1'b0;
	logic             supply_ready = 1'b0;
	logic             goodcrc_rx;
	logic             send_accept;
	logic             send_ps_rdy;
	logic             supply_change;
	logic             busy;
	logic             done;
	logic             fail;
	logic [PWR_W-1:0] sink_standby_power;
	int               errors = 0;
	int               checked = 0;
	int               n;
	int               k;
	int               seen_q[$];
	int               exp_q[$];
	logic             chg_q = 1'b0;
	logic             fail_q = 1'b0;
	always #2 ref_clk = ~ref_clk;
	pts_sequencer #(.SRC_TRANSITION_CYCLES(N), .SRC_READY_CYCLES(RDY),
		.SNK_STANDBY_CYCLES(3), .SNK_STANDBY_POWER(2500)) uut (.ref_clk, .srst,
		.request_valid, .goodcrc_rx, .supply_ready, .send_accept, .send_ps_rdy,
		.supply_change, .busy, .done, .fail, .sink_standby_power);
	pts_sink_model #(.STANDBY_CYCLES(3)) sink (.ref_clk, .srst, .send_accept,
		.send_ps_rdy, .goodcrc_rx);
	// ==========================================================
	// reference order: 0 accept, 1 change, 2 ps_rdy, 3 done, 4 fail
	// ==========================================================
	always @(posedge ref_clk) begin
		#1;
		if (send_accept === 1'b1) seen_q.push_back(0);
		if (supply_change === 1'b1 && chg_q !== 1'b1) seen_q.push_back(1);
		if (send_ps_rdy === 1'b1) seen_q.push_back(2);
		if (done === 1'b1) seen_q.push_back(3);
		if (fail === 1'b1 && fail_q !== 1'b1) seen_q.push_back(4);
		chg_q = supply_change;
		fail_q = fail;
	end
	// ==========================================================
	// checking helpers
	// ==========================================================
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// counts edges until the chosen output is high, sampled after each edge
	task automatic edges_to(input int which, input int lim, output int cnt);
		logic s;
		cnt = 0;
		s = 1'b0;
		while (s !== 1'b1 && cnt < lim) begin
			@(posedge ref_clk);
			#1;
			cnt++;
			case (which)
				0: s = send_accept;
				1: s = supply_change;
				2: s = send_ps_rdy;
				3: s = done;
				4: s = fail;
				default: s = goodcrc_rx;
			endcase
		end
		if (s !== 1'b1) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic run(input int d, input bit late);
		int k;
		seen_q.delete();
		exp_q.delete();
		exp_q.push_back(0);
		exp_q.push_back(1);
		if (late) begin
			exp_q.push_back(4);
		end else begin
			exp_q.push_back(2);
			exp_q.push_back(3);
		end
		@(posedge ref_clk) request_valid <= 1'b1;
		@(posedge ref_clk) request_valid <= 1'b0;
		edges_to(0, 8, k);
		check(k, 1);
		check({busy, fail}, 2'b10);
		edges_to(5, 8, k);
		edges_to(1, N + 8, k);
		check(k, N + 2);
		check(sink.draw, 1);
		if (late) begin
			edges_to(4, RDY + 8, k);
			check(k > RDY && k <= RDY + 3, 1);
			check({busy, fail}, 2'b01);
		end else begin
			repeat (d) @(posedge ref_clk);
			#1;
			check({send_ps_rdy, supply_change}, 2'b01);
			@(posedge ref_clk) supply_ready <= 1'b1;
			edges_to(2, 4, k);
			check(k, 1);
			check(supply_change, 1'b0);
			@(posedge ref_clk) supply_ready <= 1'b0;
			edges_to(5, 8, k);
			edges_to(3, 4, k);
			check({k[3:0], busy}, 5'h02);
			check(sink.draw, 2);
		end
		// let the order monitor finish the current edge before comparing
		#1;
		check(seen_q.size(), exp_q.size());
		while (seen_q.size() > 0 && exp_q.size() > 0) begin
			check(seen_q.pop_front(), exp_q.pop_front());
		end
		$display("test done late=%0d wait=%0d", late, d);
	endtask
	initial begin
		void'($urandom(32'hA234));
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(sink_standby_power, 16'h09C4);
		for (n = 0; n < 3; n++) begin
			run($urandom_range(RDY - 4), 1'b0);
		end
		run(RDY - 3, 1'b0);
		run(0, 1'b1);
		run(2, 1'b0);
		// reset in the middle of a sequence must drop busy, send_accept, supply_change and fail
		@(posedge ref_clk) request_valid <= 1'b1;
		@(posedge ref_clk) request_valid <= 1'b0;
		edges_to(0, 8, k);
		@(posedge ref_clk) srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		#1;
		check({busy, send_accept, supply_change, fail}, 4'h0);
		$display("test done reset mid-sequence");
		run(1, 1'b0);
		end_of_test();
	end
endmodule
